// ==== hdl/crf_pkg.sv ====
// Package: register offsets, field layouts, reset values and memory map for the CPU register file
package crf_pkg;

  // ************************************************************
  // Register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] CRF_OFF_DATA0 = 8'h00;
  localparam logic [7:0] CRF_OFF_DATA1 = 8'h04;
  localparam logic [7:0] CRF_OFF_DATA2 = 8'h08;
  localparam logic [7:0] CRF_OFF_DATA3 = 8'h0c;
  localparam logic [7:0] CRF_OFF_ADDR0 = 8'h10;
  localparam logic [7:0] CRF_OFF_ADDR1 = 8'h14;
  localparam logic [7:0] CRF_OFF_FRAME = 8'h18;
  localparam logic [7:0] CRF_OFF_PAIR_LOW = 8'h1c;
  localparam logic [7:0] CRF_OFF_PAIR_HIGH = 8'h20;
  localparam logic [7:0] CRF_OFF_ADDR_PAIR = 8'h24;
  localparam logic [7:0] CRF_OFF_BYTE0_LOW = 8'h28;
  localparam logic [7:0] CRF_OFF_BYTE0_UP = 8'h2c;
  localparam logic [7:0] CRF_OFF_BYTE1_LOW = 8'h30;
  localparam logic [7:0] CRF_OFF_BYTE1_UP = 8'h34;
  localparam logic [7:0] CRF_OFF_VECT = 8'h40;
  localparam logic [7:0] CRF_OFF_PC = 8'h44;
  localparam logic [7:0] CRF_OFF_USP = 8'h48;
  localparam logic [7:0] CRF_OFF_ISP = 8'h4c;
  localparam logic [7:0] CRF_OFF_SP = 8'h50;
  localparam logic [7:0] CRF_OFF_STATIC = 8'h54;
  localparam logic [7:0] CRF_OFF_FLAGS = 8'h58;
  localparam logic [7:0] CRF_OFF_ALU = 8'h5c;
  localparam logic [7:0] CRF_OFF_EVENT = 8'h60;
  localparam logic [7:0] CRF_OFF_DECODE = 8'h64;

  // ************************************************************
  // Flag register field positions
  // ************************************************************
  localparam int CRF_FLG_WIDTH = 11;
  localparam int CRF_FLG_CARRY = 0;
  localparam int CRF_FLG_DEBUG = 1;
  localparam int CRF_FLG_ZERO = 2;
  localparam int CRF_FLG_SIGN = 3;
  localparam int CRF_FLG_BANK = 4;
  localparam int CRF_FLG_OVFL = 5;
  localparam int CRF_FLG_IEN = 6;
  localparam int CRF_FLG_STACK = 7;
  localparam int CRF_FLG_IPL_LO = 8;
  localparam logic [10:0] CRF_FLG_WMASK = 11'h7ff;

  // ************************************************************
  // Event register fields, alu register fields
  // ************************************************************
  localparam int CRF_EVT_HW = 8;
  localparam int CRF_EVT_SW = 9;
  localparam int CRF_EVT_LVL_LO = 10;
  localparam int CRF_ALU_CARRY = 16;
  localparam int CRF_ALU_OVFL = 17;
  localparam int CRF_ALU_BYTE = 18;
  localparam logic [5:0] CRF_SW_INT_LAST = 6'h1f;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [15:0] CRF_RST_WORD = 16'h0000;
  localparam logic [19:0] CRF_RST_LONG = 20'h00000;
  localparam logic [10:0] CRF_RST_FLG = 11'h000;

  // ************************************************************
  // Address map
  // ************************************************************
  localparam logic [19:0] CRF_SFR_LAST = 20'h003ff;
  localparam logic [19:0] CRF_RAM_FIRST = 20'h00400;
  localparam logic [19:0] CRF_SPV_FIRST = 20'hffe00;
  localparam logic [19:0] CRF_SPV_LAST = 20'hfffdb;
  localparam logic [19:0] CRF_FIXV_FIRST = 20'hfffdc;

  typedef enum logic [3:0] {
    CRF_REG_SFR = 4'h1,
    CRF_REG_RAM = 4'h2,
    CRF_REG_SPV = 4'h4,
    CRF_REG_FIXV = 4'h8
  } crf_region_e;

  // Wishbone request carrier
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } crf_wb_req_s;

  // Wishbone answer carrier
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } crf_wb_rsp_s;

  // One register bank
  typedef struct packed {
    logic [3:0][15:0] data;
    logic [1:0][15:0] addr;
    logic [15:0] frame;
  } crf_bank_s;

endpackage : crf_pkg

// ==== hdl/crf_regfile.sv ====
// CPU register file with flags and address map decode, on a Wishbone slave
//
// Added by the designer: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps

module crf_regfile (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Wishbone slave
  input wire crf_pkg::crf_wb_req_s wb_req,
  output crf_pkg::crf_wb_rsp_s wb_rsp,
  // Interrupt request from the controller
  input wire logic irq_req,
  input wire logic [2:0] irq_level,
  output logic irq_accept,
  // Address map decode
  input wire logic [19:0] map_addr,
  output logic [3:0] map_region,
  // Current state views
  output logic [15:0] stack_pointer,
  output logic [19:0] program_counter_out,
  output logic [10:0] flags_out
);
  import crf_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    crf_bank_s [1:0] bank;
    logic [19:0] vect;
    logic [19:0] pc;
    logic [15:0] user_stack_pointer;
    logic [15:0] interrupt_stack_pointer;
    logic [15:0] sb;
    logic [10:0] processor_flags;
    logic ack;
    logic [31:0] rdat;
    logic accept;
    logic [3:0] region;
  } crf_state_s;

  crf_state_s cur;
  crf_state_s next_cur;

  // ************************************************************
  // Functions
  // ************************************************************
  function automatic logic [15:0] crf_merge16(input logic [15:0] old, input logic [31:0] d,
                                               input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = d[7:0];
    end
    if (sel[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction : crf_merge16

  function automatic logic [19:0] crf_merge20(input logic [19:0] old, input logic [31:0] d,
                                               input logic [3:0] sel);
    logic [19:0] r;
    r = {old[19:16], crf_merge16(old[15:0], d, sel)};
    if (sel[2]) begin
      r[19:16] = d[19:16];
    end
    return r;
  endfunction : crf_merge20

  function automatic logic [3:0] crf_decode(input logic [19:0] a);
    logic [3:0] r;
    if (a <= CRF_SFR_LAST) begin
      r = CRF_REG_SFR;
    end else if (a >= CRF_FIXV_FIRST) begin
      r = CRF_REG_FIXV;
    end else if (a >= CRF_SPV_FIRST && a <= CRF_SPV_LAST) begin
      r = CRF_REG_SPV;
    end else begin
      r = CRF_REG_RAM;
    end
    return r;
  endfunction : crf_decode

  // ************************************************************
  // Next state
  // ************************************************************
  logic b;
  logic req;
  logic wr;
  logic [16:0] sum;
  logic [15:0] a16;
  logic [15:0] b16;
  logic [15:0] res;
  logic sw_hit;
  logic hw_ok;
  logic [15:0] flg16;

  always_comb begin
    next_cur = cur;
    flg16 = 16'h0000;
    b = cur.processor_flags[CRF_FLG_BANK];
    req = wb_req.cyc && wb_req.stb && !cur.ack;
    wr = req && wb_req.we;
    next_cur.ack = req;
    next_cur.accept = 1'b0;
    next_cur.region = crf_decode(map_addr);
    a16 = wb_req.dat[15:0];
    b16 = 16'h0000;
    sum = 17'h0;
    res = 16'h0000;
    sw_hit = 1'b0;
    hw_ok = irq_req && cur.processor_flags[CRF_FLG_IEN] &&
            (irq_level > cur.processor_flags[CRF_FLG_IPL_LO +: 3]);
    next_cur.rdat = 32'h00000000;
    if (req && !wb_req.we) begin
      case (wb_req.adr)
        CRF_OFF_DATA0: next_cur.rdat = {16'h0000, cur.bank[b].data[0]};
        CRF_OFF_DATA1: next_cur.rdat = {16'h0000, cur.bank[b].data[1]};
        CRF_OFF_DATA2: next_cur.rdat = {16'h0000, cur.bank[b].data[2]};
        CRF_OFF_DATA3: next_cur.rdat = {16'h0000, cur.bank[b].data[3]};
        CRF_OFF_ADDR0: next_cur.rdat = {16'h0000, cur.bank[b].addr[0]};
        CRF_OFF_ADDR1: next_cur.rdat = {16'h0000, cur.bank[b].addr[1]};
        CRF_OFF_FRAME: next_cur.rdat = {16'h0000, cur.bank[b].frame};
        CRF_OFF_PAIR_LOW: next_cur.rdat = {cur.bank[b].data[2], cur.bank[b].data[0]};
        CRF_OFF_PAIR_HIGH: next_cur.rdat = {cur.bank[b].data[3], cur.bank[b].data[1]};
        CRF_OFF_ADDR_PAIR: next_cur.rdat = {cur.bank[b].addr[1], cur.bank[b].addr[0]};
        CRF_OFF_BYTE0_LOW: next_cur.rdat = {24'h000000, cur.bank[b].data[0][7:0]};
        CRF_OFF_BYTE0_UP: next_cur.rdat = {24'h000000, cur.bank[b].data[0][15:8]};
        CRF_OFF_BYTE1_LOW: next_cur.rdat = {24'h000000, cur.bank[b].data[1][7:0]};
        CRF_OFF_BYTE1_UP: next_cur.rdat = {24'h000000, cur.bank[b].data[1][15:8]};
        CRF_OFF_VECT: next_cur.rdat = {12'h000, cur.vect};
        CRF_OFF_PC: next_cur.rdat = {12'h000, cur.pc};
        CRF_OFF_USP: next_cur.rdat = {16'h0000, cur.user_stack_pointer};
        CRF_OFF_ISP: next_cur.rdat = {16'h0000, cur.interrupt_stack_pointer};
        CRF_OFF_SP: next_cur.rdat = {16'h0000, stack_pointer};
        CRF_OFF_STATIC: next_cur.rdat = {16'h0000, cur.sb};
        CRF_OFF_FLAGS: next_cur.rdat = {21'h0, cur.processor_flags};
        default: next_cur.rdat = 32'h00000000;
      endcase
    end
    if (wr) begin
      case (wb_req.adr)
        CRF_OFF_DATA0: next_cur.bank[b].data[0] =
          crf_merge16(cur.bank[b].data[0], wb_req.dat, wb_req.sel);
        CRF_OFF_DATA1: next_cur.bank[b].data[1] =
          crf_merge16(cur.bank[b].data[1], wb_req.dat, wb_req.sel);
        CRF_OFF_DATA2: next_cur.bank[b].data[2] =
          crf_merge16(cur.bank[b].data[2], wb_req.dat, wb_req.sel);
        CRF_OFF_DATA3: next_cur.bank[b].data[3] =
          crf_merge16(cur.bank[b].data[3], wb_req.dat, wb_req.sel);
        CRF_OFF_ADDR0: next_cur.bank[b].addr[0] =
          crf_merge16(cur.bank[b].addr[0], wb_req.dat, wb_req.sel);
        CRF_OFF_ADDR1: next_cur.bank[b].addr[1] =
          crf_merge16(cur.bank[b].addr[1], wb_req.dat, wb_req.sel);
        CRF_OFF_FRAME: next_cur.bank[b].frame =
          crf_merge16(cur.bank[b].frame, wb_req.dat, wb_req.sel);
        CRF_OFF_PAIR_LOW: begin
          next_cur.bank[b].data[0] = crf_merge16(cur.bank[b].data[0], wb_req.dat, wb_req.sel);
          next_cur.bank[b].data[2] = crf_merge16(cur.bank[b].data[2], wb_req.dat >> 16,
                                                 wb_req.sel >> 2);
        end
        CRF_OFF_PAIR_HIGH: begin
          next_cur.bank[b].data[1] = crf_merge16(cur.bank[b].data[1], wb_req.dat, wb_req.sel);
          next_cur.bank[b].data[3] = crf_merge16(cur.bank[b].data[3], wb_req.dat >> 16,
                                                 wb_req.sel >> 2);
        end
        CRF_OFF_ADDR_PAIR: begin
          next_cur.bank[b].addr[0] = crf_merge16(cur.bank[b].addr[0], wb_req.dat, wb_req.sel);
          next_cur.bank[b].addr[1] = crf_merge16(cur.bank[b].addr[1], wb_req.dat >> 16,
                                                 wb_req.sel >> 2);
        end
        CRF_OFF_BYTE0_LOW: if (wb_req.sel[0]) begin
          next_cur.bank[b].data[0][7:0] = wb_req.dat[7:0];
        end
        CRF_OFF_BYTE0_UP: if (wb_req.sel[0]) begin
          next_cur.bank[b].data[0][15:8] = wb_req.dat[7:0];
        end
        CRF_OFF_BYTE1_LOW: if (wb_req.sel[0]) begin
          next_cur.bank[b].data[1][7:0] = wb_req.dat[7:0];
        end
        CRF_OFF_BYTE1_UP: if (wb_req.sel[0]) begin
          next_cur.bank[b].data[1][15:8] = wb_req.dat[7:0];
        end
        CRF_OFF_VECT: next_cur.vect = crf_merge20(cur.vect, wb_req.dat, wb_req.sel);
        CRF_OFF_PC: next_cur.pc = crf_merge20(cur.pc, wb_req.dat, wb_req.sel);
        CRF_OFF_USP: next_cur.user_stack_pointer = crf_merge16(cur.user_stack_pointer, wb_req.dat, wb_req.sel);
        CRF_OFF_ISP: next_cur.interrupt_stack_pointer = crf_merge16(cur.interrupt_stack_pointer, wb_req.dat, wb_req.sel);
        CRF_OFF_SP: begin
          if (cur.processor_flags[CRF_FLG_STACK]) begin
            next_cur.user_stack_pointer = crf_merge16(cur.user_stack_pointer, wb_req.dat, wb_req.sel);
          end else begin
            next_cur.interrupt_stack_pointer = crf_merge16(cur.interrupt_stack_pointer, wb_req.dat, wb_req.sel);
          end
        end
        CRF_OFF_STATIC: next_cur.sb = crf_merge16(cur.sb, wb_req.dat, wb_req.sel);
        CRF_OFF_FLAGS: begin
          flg16 = crf_merge16({5'h00, cur.processor_flags}, wb_req.dat, wb_req.sel);
          next_cur.processor_flags = flg16[10:0] & CRF_FLG_WMASK;
        end
        CRF_OFF_ALU: if (wb_req.sel[2] || wb_req.sel[1] || wb_req.sel[0]) begin
          // Operand in data bits 15:0 added to data0, byte size select in bit 18; carry in and overflow in bits are ignored
          a16 = wb_req.dat[15:0];
          b16 = cur.bank[b].data[0];
          sum = {1'b0, a16} + {1'b0, b16};
          res = sum[15:0];
          next_cur.bank[b].data[0] = res;
          next_cur.processor_flags[CRF_FLG_CARRY] = wb_req.dat[CRF_ALU_BYTE] ? (a16[8] ^ b16[8] ^ res[8])
                                                                  : sum[16];
          next_cur.processor_flags[CRF_FLG_ZERO] = wb_req.dat[CRF_ALU_BYTE] ? (res[7:0] == 8'h00)
                                                                 : (res == 16'h0000);
          next_cur.processor_flags[CRF_FLG_SIGN] = wb_req.dat[CRF_ALU_BYTE] ? res[7] : res[15];
          next_cur.processor_flags[CRF_FLG_OVFL] = wb_req.dat[CRF_ALU_BYTE] ?
            ((a16[7] == b16[7]) && (res[7] != a16[7])) :
            ((a16[15] == b16[15]) && (res[15] != a16[15]));
        end
        CRF_OFF_EVENT: begin
          if (wb_req.dat[CRF_EVT_SW] && wb_req.dat[5:0] <= CRF_SW_INT_LAST) begin
            sw_hit = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    // Interrupt acceptance wins over a flag write in the same cycle
    if (hw_ok) begin
      next_cur.processor_flags[CRF_FLG_IEN] = 1'b0;
      next_cur.processor_flags[CRF_FLG_STACK] = 1'b0;
      next_cur.processor_flags[CRF_FLG_IPL_LO +: 3] = irq_level;
      next_cur.accept = 1'b1;
    end
    if (sw_hit) begin
      next_cur.processor_flags[CRF_FLG_STACK] = 1'b0;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign wb_rsp.ack = cur.ack;
  assign wb_rsp.dat = cur.rdat;
  assign irq_accept = cur.accept;
  assign map_region = cur.region;
  assign stack_pointer = cur.processor_flags[CRF_FLG_STACK] ? cur.user_stack_pointer : cur.interrupt_stack_pointer;
  assign program_counter_out = cur.pc;
  assign flags_out = cur.processor_flags;

endmodule : crf_regfile

// ==== verif/crf_regfile_assertions.sv ====
// Checker: concurrent properties on the register file ports
`timescale 1ns/1ps

module crf_regfile_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Wishbone slave
  input wire crf_pkg::crf_wb_req_s wb_req,
  input wire crf_pkg::crf_wb_rsp_s wb_rsp,
  // Interrupt
  input wire logic irq_req,
  input wire logic [2:0] irq_level,
  input wire logic irq_accept,
  // Decode and views
  input wire logic [19:0] map_addr,
  input wire logic [3:0] map_region,
  input wire logic [15:0] stack_pointer,
  input wire logic [19:0] program_counter_out,
  input wire logic [10:0] flags_out
);
  import crf_pkg::*;
  logic take_ok;
  assign take_ok = irq_req && flags_out[CRF_FLG_IEN] && (irq_level > flags_out[10:8]);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // ************************************************************
  // Bus and interrupt
  // ************************************************************
  a_ack_answer: assert property (wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack longer than one cycle");
  a_irq_cause: assert property (irq_accept |-> $past(take_ok))
    else $error("accept without enabled request");
  a_irq_result: assert property (irq_accept |-> flags_out[7:6] == 2'b00 &&
    flags_out[10:8] == $past(irq_level)) else $error("flags wrong after accept");
  a_irq_pulse: assert property (irq_accept |=> !irq_accept)
    else $error("accept longer than one cycle");
  // ************************************************************
  // Address map
  // ************************************************************
  a_map_periph: assert property (map_addr <= CRF_SFR_LAST |=> map_region == CRF_REG_SFR)
    else $error("peripheral area misdecoded");
  a_map_ram: assert property (map_addr >= CRF_RAM_FIRST && map_addr < CRF_SPV_FIRST
    |=> map_region == CRF_REG_RAM) else $error("memory area misdecoded");
  a_map_special: assert property (map_addr >= CRF_SPV_FIRST && map_addr <= CRF_SPV_LAST
    |=> map_region == CRF_REG_SPV) else $error("special page misdecoded");
  a_map_fixed: assert property (map_addr >= CRF_FIXV_FIRST |=> map_region == CRF_REG_FIXV)
    else $error("fixed vectors misdecoded");
endmodule : crf_regfile_assertions

bind crf_regfile crf_regfile_assertions chk (.clk(clk), .srst(srst), .wb_req(wb_req),
  .wb_rsp(wb_rsp), .irq_req(irq_req), .irq_level(irq_level), .irq_accept(irq_accept),
  .map_addr(map_addr), .map_region(map_region), .stack_pointer(stack_pointer),
  .program_counter_out(program_counter_out), .flags_out(flags_out));

// ==== verif/crf_regfile_bench.sv ====
// Testbench: directed scenarios for the register file
`timescale 1ns/1ps

module crf_regfile_bench;
  import crf_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  crf_wb_req_s wb_req = '0;
  crf_wb_rsp_s wb_rsp;
  logic irq_req = 1'b0;
  logic [2:0] irq_level = 3'h0;
  logic irq_accept;
  logic [19:0] map_addr = 20'h00000;
  logic [3:0] map_region;
  logic [15:0] stack_pointer;
  logic [19:0] program_counter_out;
  logic [10:0] flags_out;
  logic [31:0] rdat;
  int err_total = 0;
  int tests_run = 0;
  localparam logic [19:0] MAP_A [8] = '{20'h00000, 20'h003ff, 20'h00400, 20'hffdff,
    20'hffe00, 20'hfffdb, 20'hfffdc, 20'hfffff};
  localparam logic [3:0] MAP_R [8] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h4, 4'h4, 4'h8, 4'h8};

  always #10 clk = ~clk;

  crf_regfile dut (.clk(clk), .srst(srst), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .irq_req(irq_req), .irq_level(irq_level), .irq_accept(irq_accept),
    .map_addr(map_addr), .map_region(map_region), .stack_pointer(stack_pointer),
    .program_counter_out(program_counter_out), .flags_out(flags_out));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("MISMATCH time=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask : chk

  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                      input logic [3:0] sel);
    @(posedge clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: dat};
    do begin
      @(posedge clk);
    end while (wb_rsp.ack !== 1'b1);
    rdat = wb_rsp.dat;
    wb_req <= '0;
  endtask : xfer

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    xfer(1'b1, adr, dat, 4'hf);
  endtask : wr

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    xfer(1'b0, adr, 32'h0, 4'hf);
    chk(rdat, exp);
  endtask : rd_chk

  task automatic irq_try(input logic [2:0] lvl, input logic exp);
    @(posedge clk);
    irq_req <= 1'b1;
    irq_level <= lvl;
    @(posedge clk);
    irq_req <= 1'b0;
    @(posedge clk);
    chk({31'h0, irq_accept}, {31'h0, exp});
  endtask : irq_try

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_banks();
    wr(CRF_OFF_DATA0, 32'h1111);
    wr(CRF_OFF_FLAGS, 32'h010);
    wr(CRF_OFF_DATA0, 32'h2222);
    wr(CRF_OFF_FRAME, 32'h3333);
    rd_chk(CRF_OFF_DATA0, 32'h2222);
    wr(CRF_OFF_FLAGS, 32'h000);
    rd_chk(CRF_OFF_DATA0, 32'h1111);
    rd_chk(CRF_OFF_FRAME, 32'h0);
  endtask : t_banks

  task automatic t_split();
    wr(CRF_OFF_DATA0, 32'h1234);
    rd_chk(CRF_OFF_BYTE0_UP, 32'h12);
    xfer(1'b1, CRF_OFF_BYTE0_LOW, 32'hab, 4'h1);
    rd_chk(CRF_OFF_DATA0, 32'h12ab);
    wr(CRF_OFF_DATA1, 32'h9876);
    rd_chk(CRF_OFF_BYTE1_LOW, 32'h76);
    wr(CRF_OFF_DATA2, 32'h5678);
    wr(CRF_OFF_DATA3, 32'h4321);
    rd_chk(CRF_OFF_PAIR_LOW, 32'h567812ab);
    rd_chk(CRF_OFF_PAIR_HIGH, 32'h43219876);
    wr(CRF_OFF_ADDR_PAIR, 32'hdeadbeef);
    rd_chk(CRF_OFF_ADDR0, 32'hbeef);
    rd_chk(CRF_OFF_ADDR1, 32'hdead);
  endtask : t_split

  task automatic t_widths();
    wr(CRF_OFF_STATIC, 32'hffffffff);
    rd_chk(CRF_OFF_STATIC, 32'hffff);
    wr(CRF_OFF_VECT, 32'hffffffff);
    rd_chk(CRF_OFF_VECT, 32'hfffff);
    wr(CRF_OFF_PC, 32'hffffffff);
    chk({12'h0, program_counter_out}, 32'hfffff);
    wr(CRF_OFF_FRAME, 32'hffffffff);
    rd_chk(CRF_OFF_FRAME, 32'hffff);
    wr(CRF_OFF_FLAGS, 32'hfffffffd);
    rd_chk(CRF_OFF_FLAGS, 32'h7fd);
    rd_chk(8'h3c, 32'h0);
  endtask : t_widths

  task automatic t_stack_alu();
    wr(CRF_OFF_FLAGS, 32'h000);
    wr(CRF_OFF_USP, 32'h1000);
    wr(CRF_OFF_ISP, 32'h2000);
    chk({16'h0, stack_pointer}, 32'h2000);
    wr(CRF_OFF_FLAGS, 32'h080);
    rd_chk(CRF_OFF_SP, 32'h1000);
    wr(CRF_OFF_DATA0, 32'hffff);
    wr(CRF_OFF_ALU, 32'h1);
    rd_chk(CRF_OFF_DATA0, 32'h0);
    chk({21'h0, flags_out & 11'h02d}, 32'h005);
    wr(CRF_OFF_DATA0, 32'h7fff);
    wr(CRF_OFF_ALU, 32'h1);
    chk({21'h0, flags_out & 11'h02d}, 32'h028);
  endtask : t_stack_alu

  task automatic t_irq();
    wr(CRF_OFF_FLAGS, 32'h3c0);
    irq_try(3'h3, 1'b0);
    irq_try(3'h4, 1'b1);
    chk({21'h0, flags_out}, 32'h400);
    irq_try(3'h7, 1'b0);
    wr(CRF_OFF_FLAGS, 32'h080);
    wr(CRF_OFF_EVENT, 32'h220);
    chk({21'h0, flags_out}, 32'h080);
    wr(CRF_OFF_EVENT, 32'h21f);
    chk({21'h0, flags_out}, 32'h000);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      map_addr <= MAP_A[i];
      repeat (2) @(posedge clk);
      chk({28'h0, map_region}, {28'h0, MAP_R[i]});
    end
  endtask : t_irq

  task automatic conclude();
    if (err_total == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    t_banks();
    t_split();
    t_widths();
    t_stack_alu();
    t_irq();
    conclude();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    conclude();
  end
endmodule : crf_regfile_bench
